// ==== pkg/uiw_pkg.sv ====
// package: register map, field layout and shared types of the isochrony window bank
package uiw_pkg;

    // ==========================================
    // register byte offsets
    localparam logic [7:0] CAPABILITY_OFFSET      = 8'h00;
    localparam logic [7:0] ISOCHRONY_CONTROL_OFFSET = 8'h04;
    localparam logic [7:0] WINDOW0_CONTROL_OFFSET = 8'h08;
    localparam logic [7:0] WINDOW0_BASE_OFFSET    = 8'h0c;
    localparam logic [7:0] WINDOW0_LIMIT_OFFSET   = 8'h10;
    localparam logic [7:0] WINDOW1_CONTROL_OFFSET = 8'h14;
    localparam logic [7:0] WINDOW1_BASE_OFFSET    = 8'h18;
    localparam logic [7:0] WINDOW1_LIMIT_OFFSET   = 8'h1c;

    // ==========================================
    // field positions and reset values
    localparam int         ISOC_ENABLE_BIT      = 0;
    localparam int         TABLE_ARB_BIT        = 1;
    localparam int         AGGRESSIVE_ARB_BIT   = 2;
    localparam int         WINDOW_ENABLE_BIT    = 0;
    localparam int         TRAFFIC_CLASS_LSB    = 1;
    localparam logic [3:0] WINDOW_COUNT         = 4'h4;
    localparam logic [2:0] TRAFFIC_CLASS_ZERO   = 3'h0;
    localparam logic [31:0] WORD_RESET          = 32'h00000000;
    localparam int         WINDOW_NUM           = 2;

    // ==========================================
    // axi response codes
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ==========================================
    // arbiter steering mode
    typedef enum logic [2:0] {
        UIW_ARB_LEGACY     = 3'b001,
        UIW_ARB_TABLE      = 3'b010,
        UIW_ARB_AGGRESSIVE = 3'b100
    } uiw_arb_mode_t;

    // one window's programming
    typedef struct packed {
        logic        enable;
        logic [2:0]  traffic_class;
        logic [31:0] base;
        logic [31:0] limit;
    } uiw_window_t;

    // upstream request and its classification
    typedef struct packed {
        logic        valid;
        logic [31:0] address;
    } uiw_request_t;

    typedef struct packed {
        logic        valid;
        logic [2:0]  traffic_class;
        logic [1:0]  window_hit;
    } uiw_class_t;

endpackage

// ==== src/uiw_class_map.sv ====
// module: registered mapping of an upstream address to a traffic class
module uiw_class_map (
    input  wire logic                          aclk,
    input  wire logic                          aresetn,
    input  wire logic                          isoc_enable,
    input  wire uiw_pkg::uiw_window_t [1:0]    windows,
    input  wire uiw_pkg::uiw_request_t         request,
    output uiw_pkg::uiw_class_t                result
);
    import uiw_pkg::*;

    logic [WINDOW_NUM-1:0] hit;        // per-window match
    logic [2:0]            class_pick; // lowest hit wins
    uiw_class_t            next_result;

    // ==========================================
    // per-window comparators
    genvar gi;
    generate
        for (gi = 0; gi < WINDOW_NUM; gi = gi + 1) begin : g_match
            uiw_window_match u_match (
                .window  (windows[gi]),
                .address (request.address),
                .hit     (hit[gi])
            );
        end
    endgenerate

    // overlapping windows: window 0 has priority, a simple fixed order
    assign class_pick = hit[0] ? windows[0].traffic_class :
                        hit[1] ? windows[1].traffic_class : TRAFFIC_CLASS_ZERO;

    // global enable clear forces class zero
    assign next_result.valid         = request.valid;
    assign next_result.traffic_class = isoc_enable ? class_pick : TRAFFIC_CLASS_ZERO;
    assign next_result.window_hit    = hit;

    // ==========================================
    // output register, one cycle after request
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            result <= '0;
        end else begin
            result <= next_result;
        end
    end

endmodule

// ==== src/uiw_regs.sv ====
// module: axi4-lite register bank for upstream isochrony control and windows 0 and 1
// Function
// - control bits 15:3 read zero, ignore writes
// - aggressive bit writable only with table enable
// - aggressive mode stops masters mid transaction
// - table enable clear: legacy arbiter registers decide
// - table enable set: port table decides grant
// - global enable clear forces class zero
// - window control bits 15:4 read zero
// - window traffic class in bits 3:1
// - window enable bit 0, resets zero
// - base and limit full 32-bit read/write
// - limit is highest covered address
// - base is lowest covered address
// - control registers read zero after reset
// - capability field reports four windows
// - every reset source clears the bank
module uiw_regs (
    input  wire logic                  aclk,
    input  wire logic                  aresetn,
    input  wire logic                  hot_resetn,
    // axi4-lite slave
    input  wire logic [7:0]            s_axi_awaddr,
    input  wire logic                  s_axi_awvalid,
    output logic                       s_axi_awready,
    input  wire logic [31:0]           s_axi_wdata,
    input  wire logic [3:0]            s_axi_wstrb,
    input  wire logic                  s_axi_wvalid,
    output logic                       s_axi_wready,
    output logic [1:0]                 s_axi_bresp,
    output logic                       s_axi_bvalid,
    input  wire logic                  s_axi_bready,
    input  wire logic [7:0]            s_axi_araddr,
    input  wire logic                  s_axi_arvalid,
    output logic                       s_axi_arready,
    output logic [31:0]                s_axi_rdata,
    output logic [1:0]                 s_axi_rresp,
    output logic                       s_axi_rvalid,
    input  wire logic                  s_axi_rready,
    // upstream classification
    input  wire uiw_pkg::uiw_request_t up_request,
    output uiw_pkg::uiw_class_t        up_class,
    // secondary-bus arbiter steering
    output uiw_pkg::uiw_arb_mode_t     arb_mode,
    output logic                       arb_use_port_table,
    output logic                       arb_use_legacy_regs,
    output logic                       arb_preempt_masters
);
    import uiw_pkg::*;

    // ==========================================
    // register state
    logic              isoc_enable;      // global enable
    logic              table_arb;        // table-driven arbitration
    logic              aggressive_arb;   // preemptive arbitration
    uiw_window_t [1:0] windows;          // window programming
    logic              reset_all;        // any reset source

    // write channel capture
    logic              aw_held;          // address taken, waiting data
    logic [7:0]        aw_addr;          // captured write address
    logic              w_held;           // data taken, waiting address
    logic [31:0]       w_data;           // captured write data
    logic [3:0]        w_strb;           // captured byte enables

    // hot reset joins the bus reset; all bits are plain, none sticky
    assign reset_all = !aresetn || !hot_resetn;

    // ==========================================
    // write address / data acceptance, either order
    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready  = !w_held && !s_axi_bvalid;

    wire aw_fire = s_axi_awvalid && s_axi_awready;
    wire w_fire  = s_axi_wvalid && s_axi_wready;

    // the write commits once both halves are present
    wire        have_aw  = aw_held || aw_fire;
    wire        have_w   = w_held || w_fire;
    wire        do_write = have_aw && have_w && !s_axi_bvalid;
    wire [7:0]  wr_addr  = aw_held ? aw_addr : s_axi_awaddr;
    wire [31:0] wr_data  = w_held ? w_data : s_axi_wdata;
    wire [3:0]  wr_strb  = w_held ? w_strb : s_axi_wstrb;

    // ==========================================
    // write decode
    wire wr_ctrl    = do_write && (wr_addr == ISOCHRONY_CONTROL_OFFSET);
    wire wr_w0_ctrl = do_write && (wr_addr == WINDOW0_CONTROL_OFFSET);
    wire wr_w0_base = do_write && (wr_addr == WINDOW0_BASE_OFFSET);
    wire wr_w0_lim  = do_write && (wr_addr == WINDOW0_LIMIT_OFFSET);
    wire wr_w1_ctrl = do_write && (wr_addr == WINDOW1_CONTROL_OFFSET);
    wire wr_w1_base = do_write && (wr_addr == WINDOW1_BASE_OFFSET);
    wire wr_w1_lim  = do_write && (wr_addr == WINDOW1_LIMIT_OFFSET);
    wire wr_cap     = do_write && (wr_addr == CAPABILITY_OFFSET);
    wire wr_known   = wr_ctrl || wr_w0_ctrl || wr_w0_base || wr_w0_lim ||
                      wr_w1_ctrl || wr_w1_base || wr_w1_lim || wr_cap;

    // byte-lane merge for the 32-bit words
    function automatic logic [31:0] merge(input logic [31:0] old_v,
                                          input logic [31:0] new_v,
                                          input logic [3:0]  strb);
        logic [31:0] r;
        r = old_v;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                r[8*b +: 8] = new_v[8*b +: 8];
            end
        end
        return r;
    endfunction

    // ==========================================
    // write channel holding flops
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held  <= 1'b0;
            aw_addr <= 8'h00;
            w_data  <= WORD_RESET;
            w_strb  <= 4'h0;
        end else begin
            aw_held <= do_write ? 1'b0 : have_aw;
            w_held  <= do_write ? 1'b0 : have_w;
            if (aw_fire) begin
                aw_addr <= s_axi_awaddr;
            end
            if (w_fire) begin
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
        end
    end

    // write response, one cycle after commit, held until bready
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_known ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ==========================================
    // global control register; only bits 2:0 exist
    wire ctrl_lane0        = wr_ctrl && wr_strb[0];
    wire next_table_arb    = ctrl_lane0 ? wr_data[TABLE_ARB_BIT] : table_arb;
    // aggressive bit only sticks while table mode is (being) set, and clears with it
    wire next_aggressive   = !next_table_arb ? 1'b0 :
                             ctrl_lane0 ? wr_data[AGGRESSIVE_ARB_BIT] : aggressive_arb;

    always_ff @(posedge aclk) begin
        if (reset_all) begin
            isoc_enable    <= 1'b0;
            table_arb      <= 1'b0;
            aggressive_arb <= 1'b0;
        end else begin
            if (ctrl_lane0) begin
                isoc_enable <= wr_data[ISOC_ENABLE_BIT];
            end
            table_arb      <= next_table_arb;
            aggressive_arb <= next_aggressive;
        end
    end

    // ==========================================
    // window registers, one generate slice per window
    wire [1:0] wr_wctrl = {wr_w1_ctrl, wr_w0_ctrl};
    wire [1:0] wr_wbase = {wr_w1_base, wr_w0_base};
    wire [1:0] wr_wlim  = {wr_w1_lim, wr_w0_lim};

    genvar gw;
    generate
        for (gw = 0; gw < WINDOW_NUM; gw = gw + 1) begin : g_win
            always_ff @(posedge aclk) begin
                if (reset_all) begin
                    windows[gw].enable        <= 1'b0;
                    windows[gw].traffic_class <= TRAFFIC_CLASS_ZERO;
                    windows[gw].base          <= WORD_RESET;
                    windows[gw].limit         <= WORD_RESET;
                end else begin
                    // control: bits 15:4 are not stored
                    if (wr_wctrl[gw] && wr_strb[0]) begin
                        windows[gw].enable        <= wr_data[WINDOW_ENABLE_BIT];
                        windows[gw].traffic_class <= wr_data[TRAFFIC_CLASS_LSB +: 3];
                    end
                    // base and limit stored even with window disabled (scratch)
                    if (wr_wbase[gw]) begin
                        windows[gw].base <= merge(windows[gw].base, wr_data, wr_strb);
                    end
                    if (wr_wlim[gw]) begin
                        windows[gw].limit <= merge(windows[gw].limit, wr_data, wr_strb);
                    end
                end
            end
        end
    endgenerate

    // ==========================================
    // read channel: one read in flight, data registered
    assign s_axi_arready = !s_axi_rvalid;
    wire   ar_fire       = s_axi_arvalid && s_axi_arready;

    logic [31:0] rd_word;   // selected read value
    logic        rd_known;  // address decodes

    // reserved bits of each register come back as zero
    always_comb begin
        rd_word  = WORD_RESET;
        rd_known = 1'b1;
        case (s_axi_araddr)
            CAPABILITY_OFFSET:        rd_word = {28'h0000000, WINDOW_COUNT};
            ISOCHRONY_CONTROL_OFFSET: rd_word = {29'h0, aggressive_arb, table_arb, isoc_enable};
            WINDOW0_CONTROL_OFFSET:   rd_word = {28'h0000000, windows[0].traffic_class, windows[0].enable};
            WINDOW0_BASE_OFFSET:      rd_word = windows[0].base;
            WINDOW0_LIMIT_OFFSET:     rd_word = windows[0].limit;
            WINDOW1_CONTROL_OFFSET:   rd_word = {28'h0000000, windows[1].traffic_class, windows[1].enable};
            WINDOW1_BASE_OFFSET:      rd_word = windows[1].base;
            WINDOW1_LIMIT_OFFSET:     rd_word = windows[1].limit;
            default:                  rd_known = 1'b0;
        endcase
    end

    // read data registered, held until rready
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= WORD_RESET;
            s_axi_rresp  <= RESP_OKAY;
        end else if (ar_fire) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_word;
            s_axi_rresp  <= rd_known ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ==========================================
    // arbiter steering, straight from the control flops
    always_comb begin
        if (!table_arb) begin
            arb_mode = UIW_ARB_LEGACY;
        end else if (aggressive_arb) begin
            arb_mode = UIW_ARB_AGGRESSIVE;
        end else begin
            arb_mode = UIW_ARB_TABLE;
        end
    end

    assign arb_use_legacy_regs = !table_arb;
    assign arb_use_port_table  = table_arb;
    assign arb_preempt_masters = table_arb && aggressive_arb;

    // ==========================================
    // upstream traffic classification
    uiw_class_map u_class_map (
        .aclk        (aclk),
        .aresetn     (!reset_all),
        .isoc_enable (isoc_enable),
        .windows     (windows),
        .request     (up_request),
        .result      (up_class)
    );

endmodule

// ==== src/uiw_window_match.sv ====
// module: one window's inclusive address comparison
module uiw_window_match (
    input  wire uiw_pkg::uiw_window_t window,
    input  wire logic [31:0]          address,
    output logic                      hit
);
    import uiw_pkg::*;

    // ==========================================
    // compare
    wire above_base  = (address >= window.base);
    wire below_limit = (address <= window.limit);

    // bounds both included; disabled window never hits
    assign hit = window.enable & above_base & below_limit;

endmodule

// ==== tb/uiw_regs_checker.sv ====
// checker: handshake, steering and classifier assertions for the isochrony register bank
module uiw_regs_checker (
    input wire logic                  aclk,
    input wire logic                  aresetn,
    input wire logic                  hot_resetn,
    input wire logic                  s_axi_awvalid,
    input wire logic                  s_axi_awready,
    input wire logic                  s_axi_wvalid,
    input wire logic                  s_axi_wready,
    input wire logic                  s_axi_bvalid,
    input wire logic                  s_axi_arvalid,
    input wire logic                  s_axi_arready,
    input wire logic                  s_axi_rvalid,
    input wire uiw_pkg::uiw_request_t up_request,
    input wire uiw_pkg::uiw_class_t   up_class,
    input wire uiw_pkg::uiw_arb_mode_t arb_mode,
    input wire logic                  arb_use_port_table,
    input wire logic                  arb_use_legacy_regs,
    input wire logic                  arb_preempt_masters
);
    timeunit 1ns;
    timeprecision 1ps;
    import uiw_pkg::*;

    // ==========================================
    // one domain: hot reset leaves the bus flops alone, so only aresetn disables
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    // ==========================================
    // arbiter steering
    a_legacy_steer: assert property (arb_use_legacy_regs == (arb_mode == UIW_ARB_LEGACY))
        else $error("legacy steering disagrees with mode");
    a_table_steer: assert property (arb_use_port_table == !arb_use_legacy_regs)
        else $error("port table and legacy steering overlap");
    a_preempt_table: assert property (arb_preempt_masters |->
        arb_use_port_table && arb_mode == UIW_ARB_AGGRESSIVE)
        else $error("preemption without table arbitration");
    // ==========================================
    // classifier: guard skips the edge right after either reset lifts
    a_class_latency: assert property ($past(aresetn && hot_resetn) |->
        up_class.valid == $past(up_request.valid))
        else $error("class result not one cycle after request");
    a_miss_class_zero: assert property (up_class.valid && up_class.window_hit == 2'h0 |->
        up_class.traffic_class == TRAFFIC_CLASS_ZERO)
        else $error("class given without a window hit");
    // ==========================================
    // register bus
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid)
        else $error("write answer late");
    a_ar_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address taken while answer pending");
    a_aw_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while response pending");
endmodule

bind uiw_regs uiw_regs_checker chk_u (.aclk(aclk), .aresetn(aresetn), .hot_resetn(hot_resetn),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .up_request(up_request), .up_class(up_class),
    .arb_mode(arb_mode), .arb_use_port_table(arb_use_port_table), .arb_use_legacy_regs(arb_use_legacy_regs),
    .arb_preempt_masters(arb_preempt_masters));

// ==== tb/uiw_regs_test.sv ====
// testbench: register access, arbiter steering and window classification of the bank
module uiw_regs_test;
    timeunit 1ns;
    timeprecision 1ps;
    import uiw_pkg::*;

    // ==========================================
    // stimulus and observed signals
    logic          aclk = 1'h0, aresetn = 1'h0, hot_resetn = 1'h1;
    logic [7:0]    awaddr = 8'h00, araddr = 8'h00;
    logic          awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
    logic [31:0]   wdata = 32'h0, rdata, v, w, m;
    logic [3:0]    wstrb = 4'h0, s;
    logic          awready, wready, bvalid, arready, rvalid, use_table, use_legacy, preempt;
    logic [1:0]    bresp, rresp;
    uiw_request_t  up_request = '0;
    uiw_class_t    up_class;
    uiw_arb_mode_t arb_mode;
    int            err_total = 0, tests_run = 0, cycles = 0;
    logic [33:0]   rq[$];                 // expected {rresp, rdata}
    logic [1:0]    bq[$];                 // expected bresp
    uiw_class_t    cq[$];                 // expected classifier results
    logic [7:0]    bl[4] = '{WINDOW0_BASE_OFFSET, WINDOW0_LIMIT_OFFSET, WINDOW1_BASE_OFFSET, WINDOW1_LIMIT_OFFSET};

    initial forever #12.5 aclk = ~aclk;

    uiw_regs dut_u (.aclk(aclk), .aresetn(aresetn), .hot_resetn(hot_resetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .up_request(up_request), .up_class(up_class), .arb_mode(arb_mode), .arb_use_port_table(use_table),
        .arb_use_legacy_regs(use_legacy), .arb_preempt_masters(preempt));

    // ==========================================
    // comparison and verdict
    task automatic chk(input string name, input logic [33:0] seen, input logic [33:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic tally_and_finish();
        // a note never answered is a missed result
        err_total += rq.size() + bq.size() + cq.size();
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // ==========================================
    // bus masters: readiness sampled at the falling edge, which equals the next rising edge
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] st, input logic [1:0] r);
        logic aw_ok, w_ok, b_ok;
        bq.push_back(r);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        wstrb <= st;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        // no cycle count assumed: the wait ends once bvalid is seen, the hang guard catches a stall
        forever begin
            @(negedge aclk);
            aw_ok = awvalid && awready;
            w_ok = wvalid && wready;
            b_ok = bvalid;
            @(posedge aclk);
            if (aw_ok) awvalid <= 1'h0;
            if (w_ok) wvalid <= 1'h0;
            if (b_ok) begin
                bready <= 1'h0;
                break;
            end
        end
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        logic ar_ok, r_ok;
        rq.push_back({r, d});
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        forever begin
            @(negedge aclk);
            ar_ok = arvalid && arready;
            r_ok = rvalid;
            @(posedge aclk);
            if (ar_ok) arvalid <= 1'h0;
            if (r_ok) begin
                rready <= 1'h0;
                break;
            end
        end
    endtask

    // control write, read back, then steering outputs {mode, preempt, table, legacy}
    task automatic ctl(input logic [31:0] d, input logic [31:0] e, input logic [5:0] st);
        wr(ISOCHRONY_CONTROL_OFFSET, d, 4'hf, RESP_OKAY);
        rd(ISOCHRONY_CONTROL_OFFSET, e, RESP_OKAY);
        chk("arb_steer", {arb_mode, preempt, use_table, use_legacy}, st);
    endtask

    // one-cycle upstream request with its expected class
    task automatic req(input logic [31:0] a, input logic [2:0] tc, input logic [1:0] hit);
        cq.push_back({1'h1, tc, hit});
        @(posedge aclk);
        up_request <= {1'h1, a};
        @(posedge aclk);
        up_request <= '0;
    endtask

    // ==========================================
    // result watcher: oldest note against each answer
    always @(negedge aclk) begin
        // an answer with no note behind it is compared against its own inverse, so it fails
        if (rvalid && rready)
            chk("rdata", {rresp, rdata}, rq.size() ? rq.pop_front() : ~{rresp, rdata});
        if (bvalid && bready)
            chk("bresp", bresp, bq.size() ? bq.pop_front() : ~bresp);
        if (up_class.valid)
            chk("class", up_class, cq.size() ? cq.pop_front() : ~up_class);
    end

    // hang guard: the sequence needs well under this many cycles
    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            err_total++;
            tally_and_finish();
        end
    end

    initial begin
        void'($urandom(32'hadf6177f));
        repeat (6) @(posedge aclk);
        aresetn <= 1'h1;
        // reset values, capability count and one unmapped place
        for (int i = 0; i < 9; i++) rd(8'(i * 4), i == 0 ? 32'h4 : 32'h0, i == 8 ? RESP_SLVERR : RESP_OKAY);
        wr(8'h20, $urandom, 4'hf, RESP_SLVERR);
        wr(CAPABILITY_OFFSET, 32'hffffffff, 4'hf, RESP_OKAY);
        rd(CAPABILITY_OFFSET, 32'h4, RESP_OKAY);
        // control bits, aggressive only beside table arbitration
        ctl(32'h0000fffd, 32'h1, 6'h09);
        ctl(32'hffffffff, 32'h7, 6'h26);
        ctl(32'h2, 32'h2, 6'h12);
        ctl(32'h4, 32'h0, 6'h09);
        ctl(32'h6, 32'h6, 6'h26);
        // window control: reserved bits drop, class and enable kept
        wr(WINDOW0_CONTROL_OFFSET, 32'hfffffffb, 4'hf, RESP_OKAY);
        rd(WINDOW0_CONTROL_OFFSET, 32'hb, RESP_OKAY);
        wr(WINDOW1_CONTROL_OFFSET, 32'hfffffff7, 4'hf, RESP_OKAY);
        rd(WINDOW1_CONTROL_OFFSET, 32'h7, RESP_OKAY);
        // base and limit: full words then random byte strobes
        for (int i = 0; i < 4; i++) begin
            v = $urandom;
            w = $urandom;
            s = 4'($urandom);
            for (int b = 0; b < 4; b++) m[b * 8 +: 8] = {8{s[b]}};
            wr(bl[i], v, 4'hf, RESP_OKAY);
            wr(bl[i], w, s, RESP_OKAY);
            rd(bl[i], (w & m) | (v & ~m), RESP_OKAY);
        end
        // overlapping windows 1000-1fff class 5 and 1800-2fff class 3
        wr(WINDOW0_BASE_OFFSET, 32'h1000, 4'hf, RESP_OKAY);
        wr(WINDOW0_LIMIT_OFFSET, 32'h1fff, 4'hf, RESP_OKAY);
        wr(WINDOW1_BASE_OFFSET, 32'h1800, 4'hf, RESP_OKAY);
        wr(WINDOW1_LIMIT_OFFSET, 32'h2fff, 4'hf, RESP_OKAY);
        ctl(32'h1, 32'h1, 6'h09);
        req(32'h0fff, 3'h0, 2'h0);
        req(32'h1000, 3'h5, 2'h1);
        req(32'h1fff, 3'h5, 2'h3);
        req(32'h2fff, 3'h3, 2'h2);
        req(32'h3000, 3'h0, 2'h0);
        for (int i = 0; i < 4; i++) req(32'h1000 | (32'($urandom) & 32'h7ff), 3'h5, 2'h1);
        // global enable off keeps class zero while hits still show
        ctl(32'h2, 32'h2, 6'h12);
        req(32'h1000, 3'h0, 2'h1);
        req(32'h2000, 3'h0, 2'h2);
        // window 0 disabled no longer hits
        ctl(32'h1, 32'h1, 6'h09);
        wr(WINDOW0_CONTROL_OFFSET, 32'ha, 4'hf, RESP_OKAY);
        req(32'h1000, 3'h0, 2'h0);
        req(32'h1800, 3'h3, 2'h2);
        // link hot reset clears the bank
        @(posedge aclk);
        hot_resetn <= 1'h0;
        @(posedge aclk);
        hot_resetn <= 1'h1;
        rd(ISOCHRONY_CONTROL_OFFSET, 32'h0, RESP_OKAY);
        rd(WINDOW1_CONTROL_OFFSET, 32'h0, RESP_OKAY);
        rd(WINDOW0_BASE_OFFSET, 32'h0, RESP_OKAY);
        repeat (4) @(posedge aclk);
        tally_and_finish();
    end
endmodule
